/* rtl/fesc_pkg.sv */
package fesc_pkg;

    localparam int CLK_MHZ = 250;
    localparam int STROBE_CYC = 10;       // 40 ns per strobe phase, covers 35 ns pulses
    localparam int ADDR_W = 20;
    localparam int DATA_W = 16;

    localparam logic [11:0] UNLOCK_ADDR1 = 12'h555;
    localparam logic [11:0] UNLOCK_ADDR2 = 12'hAAA;
    localparam logic [7:0]  UNLOCK_DATA1 = 8'hAA;
    localparam logic [7:0]  UNLOCK_DATA2 = 8'h55;
    localparam logic [7:0]  ERASE_SETUP  = 8'h80;
    localparam logic [7:0]  CHIP_ERASE   = 8'h10;
    localparam logic [7:0]  SECTOR_ERASE = 8'h30;
    localparam logic [7:0]  ID_ENTRY     = 8'h90;
    localparam logic [7:0]  ID_EXIT      = 8'hF0;
    localparam int TOGGLE_BIT = 6;

    // worst-case times in milliseconds; chip erase timeout at typical x2
    localparam int SEC_SMALL_MAX_MS = 3000;
    localparam int SEC_LARGE_MAX_MS = 5000;
    localparam int CHIP_TMO_MS      = 50000;
    localparam longint CYC_PER_MS   = longint'(CLK_MHZ) * 1000;

    typedef enum logic [1:0] {FESC_OP_CHIP, FESC_OP_SECTOR, FESC_OP_ID_ENTRY,
                              FESC_OP_ID_EXIT} fesc_op_t;

endpackage

/* rtl/fesc_bus_cycle.sv */
`timescale 1ns/1ns
// one write or read strobe cycle on the flash pins
module fesc_bus_cycle
    import fesc_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              start,
    input  wire logic              is_write,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic [DATA_W-1:0] dq_in,
    output logic                   done_q,
    output logic [DATA_W-1:0]      rdata_q,
    output logic                   ce_n_q,
    output logic                   oe_n_q,
    output logic                   we_n_q,
    output logic [ADDR_W-1:0]      a_q,
    output logic [DATA_W-1:0]      dq_out_q,
    output logic                   dq_oe_q
);

    logic [DATA_W-1:0] dq_s1_q;
    logic [DATA_W-1:0] dq_s2_q;
    logic [4:0]        cnt_q;
    logic [1:0]        ph_q;
    logic              wr_q;
    wire               tick = (cnt_q == 5'(STROBE_CYC - 1));

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk)
    begin
        dq_s1_q <= dq_in;
        dq_s2_q <= dq_s1_q;
    end

    // phases: 0 idle, 1 setup, 2 strobe low, 3 recovery high
    always_ff @(posedge clk)
    begin
        done_q <= 1'b0;
        if (rst)
        begin
            ph_q <= 2'd0; cnt_q <= '0; ce_n_q <= 1'b1; oe_n_q <= 1'b1;
            we_n_q <= 1'b1; dq_oe_q <= 1'b0; a_q <= '0; dq_out_q <= '0;
            rdata_q <= '0; wr_q <= 1'b0;
        end
        else if (ph_q == 2'd0)
        begin
            cnt_q <= '0;
            if (start)
            begin
                ph_q <= 2'd1; a_q <= addr; dq_out_q <= wdata; wr_q <= is_write;
                dq_oe_q <= is_write; ce_n_q <= 1'b0;
            end
        end
        else
        begin
            cnt_q <= tick ? '0 : cnt_q + 5'd1;
            if (tick)
            begin
                ph_q <= ph_q + 2'd1;
                if (ph_q == 2'd1)
                begin
                    we_n_q <= ~wr_q;
                    oe_n_q <= wr_q;  // each read toggles output enable
                end
                else if (ph_q == 2'd2)
                begin
                    if (!wr_q)
                        rdata_q <= dq_s2_q;
                    we_n_q <= 1'b1; oe_n_q <= 1'b1; ce_n_q <= 1'b1;
                end
                else
                begin
                    dq_oe_q <= 1'b0; done_q <= 1'b1;
                end
            end
        end
    end

endmodule

/* rtl/fesc_ctrl.sv */
`timescale 1ns/1ns
module fesc_ctrl
    import fesc_pkg::*;
#(
    parameter longint SEC_SMALL_TMO_CYC = longint'(SEC_SMALL_MAX_MS) * CYC_PER_MS,
    parameter longint SEC_LARGE_TMO_CYC = longint'(SEC_LARGE_MAX_MS) * CYC_PER_MS,
    parameter longint CHIP_TMO_CYC      = longint'(CHIP_TMO_MS) * CYC_PER_MS
)
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              req,
    input  wire fesc_op_t          op,
    input  wire logic [ADDR_W-1:0] req_addr,
    input  wire logic              sector_large,
    input  wire logic [DATA_W-1:0] dq_in,
    output logic                   busy_q,
    output logic                   done_q,
    output logic                   timeout_q,
    output logic                   id_mode_q,
    output logic [DATA_W-1:0]      maker_code_q,
    output logic [DATA_W-1:0]      device_code_q,
    output logic                   ce_n,
    output logic                   oe_n,
    output logic                   we_n,
    output logic [ADDR_W-1:0]      a,
    output logic [DATA_W-1:0]      dq_out,
    output logic                   dq_oe
);

    typedef enum logic [2:0] {S_IDLE, S_CMD, S_POLL, S_IDRD, S_END} fesc_state_t;

    fesc_state_t       st_q;
    fesc_op_t          op_q;
    logic [2:0]        step_q;
    logic [ADDR_W-1:0] addr_q;
    logic              large_q;
    logic              go_q;
    logic              iswr_q;
    logic [ADDR_W-1:0] baddr_q;
    logic [DATA_W-1:0] bdata_q;
    logic              have_prev_q;
    logic              prev_tog_q;
    logic [35:0]       tmo_q;
    logic              cyc_done;
    logic [DATA_W-1:0] rdata;

    ////////////////////////////////////////////////////////////////////////////////
    // command table: step -> (address low bits, byte); high bits zero
    wire [2:0]  n_steps = (op_q == FESC_OP_CHIP || op_q == FESC_OP_SECTOR) ? 3'd6 :
                          (op_q == FESC_OP_ID_ENTRY) ? 3'd3 : 3'd3;
    wire        last_step = (step_q == n_steps - 3'd1);
    wire [7:0]  final_byte = (op_q == FESC_OP_CHIP) ? CHIP_ERASE : SECTOR_ERASE;
    // next word is looked up with the incremented step
    wire [2:0]  nstep = step_q + 3'd1;
    wire [11:0] n_taddr = (nstep == 3'd1 || nstep == 3'd4) ? UNLOCK_ADDR2 : UNLOCK_ADDR1;
    wire [7:0]  n_tbyte = (nstep == 3'd0 || nstep == 3'd3) ? UNLOCK_DATA1 :
                          (nstep == 3'd1 || nstep == 3'd4) ? UNLOCK_DATA2 :
                          (op_q == FESC_OP_ID_ENTRY) ? ID_ENTRY :
                          (op_q == FESC_OP_ID_EXIT)  ? ID_EXIT : ERASE_SETUP;
    wire        n_elast = (op_q == FESC_OP_CHIP || op_q == FESC_OP_SECTOR) && nstep == 3'd5;
    // sector erase carries the target sector address; chip erase uses 555
    wire [ADDR_W-1:0] cmd_addr_next = (n_elast && op_q == FESC_OP_SECTOR) ? addr_q :
                                      {{(ADDR_W-12){1'b0}}, n_taddr};
    // command on lower byte, upper byte driven zero
    wire [DATA_W-1:0] cmd_data_next = {{(DATA_W-8){1'b0}}, n_elast ? final_byte : n_tbyte};
    wire        cur_tog = rdata[TOGGLE_BIT];
    // only equality of two reads matters, never the value
    wire        settled = have_prev_q && (cur_tog == prev_tog_q);
    wire [35:0] tmo_lim = (op_q == FESC_OP_CHIP) ? 36'(CHIP_TMO_CYC) :
                          large_q ? 36'(SEC_LARGE_TMO_CYC) : 36'(SEC_SMALL_TMO_CYC);
    wire        tmo_hit = (tmo_q >= tmo_lim);

    ////////////////////////////////////////////////////////////////////////////////
    fesc_bus_cycle u_cyc (
        .clk      (clk),
        .rst      (rst),
        .start    (go_q),
        .is_write (iswr_q),
        .addr     (baddr_q),
        .wdata    (bdata_q),
        .dq_in    (dq_in),
        .done_q   (cyc_done),
        .rdata_q  (rdata),
        .ce_n_q   (ce_n),
        .oe_n_q   (oe_n),
        .we_n_q   (we_n),
        .a_q      (a),
        .dq_out_q (dq_out),
        .dq_oe_q  (dq_oe)
    );

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk)
    begin
        go_q   <= 1'b0;
        done_q <= 1'b0;
        if (rst)
        begin
            st_q <= S_IDLE; op_q <= FESC_OP_CHIP; step_q <= '0; addr_q <= '0;
            large_q <= 1'b0; iswr_q <= 1'b0; baddr_q <= '0; bdata_q <= '0;
            have_prev_q <= 1'b0; prev_tog_q <= 1'b0; tmo_q <= '0; busy_q <= 1'b0;
            timeout_q <= 1'b0; id_mode_q <= 1'b0; maker_code_q <= '0;
            device_code_q <= '0;
        end
        else
        begin
            unique case (st_q)
                S_IDLE:
                begin
                    if (req)
                    begin
                        st_q <= S_CMD; op_q <= op; addr_q <= req_addr;
                        large_q <= sector_large; step_q <= '0; busy_q <= 1'b1;
                        timeout_q <= 1'b0; go_q <= 1'b1; iswr_q <= 1'b1;
                        // first word of every sequence: 555/AA
                        baddr_q <= {{(ADDR_W-12){1'b0}}, UNLOCK_ADDR1};
                        bdata_q <= {{(DATA_W-8){1'b0}}, UNLOCK_DATA1};
                    end
                end
                S_CMD:
                begin
                    if (cyc_done)
                    begin
                        if (!last_step)
                        begin
                            step_q <= step_q + 3'd1; go_q <= 1'b1;
                            baddr_q <= cmd_addr_next; bdata_q <= cmd_data_next;
                        end
                        else if (op_q == FESC_OP_ID_ENTRY)
                        begin
                            // id read at all-low address, bit 0 picks code
                            st_q <= S_IDRD; step_q <= '0; go_q <= 1'b1; iswr_q <= 1'b0;
                            baddr_q <= '0; id_mode_q <= 1'b1;
                        end
                        else if (op_q == FESC_OP_ID_EXIT)
                        begin
                            id_mode_q <= 1'b0; st_q <= S_END;
                        end
                        else
                        begin
                            // fixed poll address for the whole poll
                            st_q <= S_POLL; go_q <= 1'b1; iswr_q <= 1'b0;
                            baddr_q <= addr_q; have_prev_q <= 1'b0; tmo_q <= '0;
                        end
                    end
                end
                S_POLL:
                begin
                    tmo_q <= tmo_q + 36'd1;
                    if (cyc_done)
                    begin
                        // each read is a fresh output-enable pulse
                        prev_tog_q <= cur_tog; have_prev_q <= 1'b1;
                        if (settled)
                            st_q <= S_END;
                        else if (tmo_hit)
                        begin
                            timeout_q <= 1'b1; st_q <= S_END;
                        end
                        else
                            go_q <= 1'b1;
                    end
                end
                S_IDRD:
                begin
                    if (cyc_done)
                    begin
                        if (step_q == 3'd0)
                        begin
                            maker_code_q <= rdata; step_q <= 3'd1; go_q <= 1'b1;
                            baddr_q <= {{(ADDR_W-1){1'b0}}, 1'b1};
                        end
                        else
                        begin
                            device_code_q <= rdata; st_q <= S_END;
                        end
                    end
                end
                S_END:
                begin
                    busy_q <= 1'b0; done_q <= 1'b1; st_q <= S_IDLE;
                end
            endcase
        end
    end

endmodule

/* dv/fesc_monitor.sv */
`timescale 1ns/1ns
module fesc_monitor
    import fesc_pkg::*;
(
    input wire logic              clk,
    input wire logic              rst,
    input wire logic              req,
    input wire fesc_op_t          op,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic              busy_q,
    input wire logic              done_q,
    input wire logic              timeout_q,
    input wire logic              oe_n,
    input wire logic              we_n,
    input wire logic [ADDR_W-1:0] a,
    input wire logic [DATA_W-1:0] dq_out,
    input wire logic              dq_oe
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////////
    sequence s_taken;
        req && !busy_q;
    endsequence
    // write strobe stays low for exactly ten cycles
    sequence s_wr_pulse;
        (!we_n)[*8] ##1 !we_n ##1 we_n;
    endsequence
    chk_req_taken: assert property (s_taken |=> busy_q) else $error("request not taken");
    chk_done_pulse: assert property (done_q |=> !done_q) else $error("done too long");
    chk_wr_width: assert property ($fell(we_n) |=> s_wr_pulse) else $error("write width");
    chk_cmd_byte: assert property (!we_n |-> dq_oe && dq_out[15:8] == 8'h00)
        else $error("command byte");
    chk_read_float: assert property (!oe_n |-> !dq_oe && we_n)
        else $error("drive during read");
    chk_chip_final: assert property (!we_n && dq_out[7:0] == CHIP_ERASE
        |-> a == 20'h00555 && op == FESC_OP_CHIP) else $error("chip erase write");
    chk_sect_final: assert property (!we_n && dq_out[7:0] == SECTOR_ERASE
        |-> a == req_addr && op == FESC_OP_SECTOR) else $error("sector erase write");
    chk_poll_addr: assert property (!oe_n && busy_q && op != FESC_OP_ID_ENTRY
        |-> a == req_addr) else $error("poll address moved");
    chk_tmo_done: assert property ($rose(timeout_q) |=> done_q) else $error("timeout");
endmodule

/* dv/fesc_flash_model.sv */
`timescale 1ns/1ns
module fesc_flash_model
    import fesc_pkg::*;
#(
    parameter int          BUSY_READS = 5,
    parameter logic [15:0] MAKER_ID   = 16'h00A5, // arbitrary value
    parameter logic [15:0] DEV_ID     = 16'h005A  // arbitrary value
)
(
    input  wire logic              ce_n,
    input  wire logic              oe_n,
    input  wire logic              we_n,
    input  wire logic              pwr_off,
    input  wire logic              stuck,
    input  wire logic [ADDR_W-1:0] a,
    input  wire logic [DATA_W-1:0] dq_out,
    output logic      [DATA_W-1:0] dq_in,
    output logic      [ADDR_W-1:0] erase_addr,
    output logic      [7:0]        erase_cmd,
    output logic                   id_on
);
    logic [19:0]       hist [0:2];
    logic [DATA_W-1:0] last = 16'h0000;
    logic              tog  = 1'b0;
    int                busy = 0;
    wire        wr_end = we_n | ce_n;
    wire        rd_end = oe_n | ce_n;
    wire [11:0] ca     = a[11:0];
    wire [7:0]  cd     = dq_out[7:0];
    wire        unl    = hist[1] == {UNLOCK_ADDR1, UNLOCK_DATA1} &&
                         hist[0] == {UNLOCK_ADDR2, UNLOCK_DATA2};
    wire [DATA_W-1:0] rd_val = id_on ? (a[0] ? DEV_ID : MAKER_ID)
                                     : (16'hFFBF | {9'h000, tog, 6'h00});
    initial
    begin
        hist = '{20'h00000, 20'h00000, 20'h00000};
        id_on = 1'b0;
        erase_cmd = 8'h00;
        erase_addr = '0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge wr_end)
    begin
        if (unl && ca == UNLOCK_ADDR1 && cd == ID_ENTRY)
            id_on = 1'b1;
        // both exit forms end in the same byte
        if (cd == ID_EXIT)
            id_on = 1'b0;
        if (unl && hist[2] == {UNLOCK_ADDR1, ERASE_SETUP} &&
            ((cd == CHIP_ERASE && ca == UNLOCK_ADDR1) || cd == SECTOR_ERASE))
        begin
            erase_cmd = cd;
            erase_addr = a;
            busy = BUSY_READS; // time scaled to reads
        end
        hist[2] = hist[1];
        hist[1] = hist[0];
        hist[0] = {ca, cd};
    end
    // either strobe ends a status read
    always @(posedge rd_end)
    begin
        last = rd_val;
        if (we_n && (busy > 0 || stuck))
        begin
            tog = ~tog;
            busy = (busy > 0) ? busy - 1 : 0;
        end
    end
    always @(posedge pwr_off) id_on = 1'b0;
    // released bus shows the inverse, never a convenient stale value
    always @* dq_in = (!ce_n && !oe_n) ? rd_val : ~last;
endmodule

/* dv/fesc_ctrl_tb_top.sv */
`timescale 1ns/1ns
module fesc_ctrl_tb_top;
    import fesc_pkg::*;
    localparam logic [15:0] MAKER = 16'h00A5; // arbitrary value
    localparam logic [15:0] DEVID = 16'h005A; // arbitrary value
    logic              clk = 0, rst = 1, req = 0, sector_large = 0, pwr_off = 0, stuck = 0;
    fesc_op_t          op = FESC_OP_CHIP, o;
    logic [ADDR_W-1:0] req_addr = '0, a, erase_addr, ad;
    logic [DATA_W-1:0] dq_in, dq_out, maker_code_q, device_code_q;
    logic              busy_q, done_q, timeout_q, id_mode_q, ce_n, oe_n, we_n, dq_oe, id_on;
    logic [7:0]        erase_cmd;
    int                err_count = 0, samples_checked = 0, cyc = 0;
    always #2 clk = ~clk;
    fesc_ctrl #(.SEC_SMALL_TMO_CYC(2000), .SEC_LARGE_TMO_CYC(3000), .CHIP_TMO_CYC(4000))
    i_fesc_ctrl (.clk(clk), .rst(rst), .req(req), .op(op), .req_addr(req_addr),
        .sector_large(sector_large), .dq_in(dq_in), .busy_q(busy_q), .done_q(done_q),
        .timeout_q(timeout_q), .id_mode_q(id_mode_q), .maker_code_q(maker_code_q),
        .device_code_q(device_code_q), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .a(a),
        .dq_out(dq_out), .dq_oe(dq_oe));
    fesc_flash_model i_fesc_flash_model (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
        .pwr_off(pwr_off), .stuck(stuck), .a(a), .dq_out(dq_out), .dq_in(dq_in),
        .erase_addr(erase_addr), .erase_cmd(erase_cmd), .id_on(id_on));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    function automatic logic [15:0] exp_code(input logic sel);
        return sel ? DEVID : MAKER;
    endfunction
    function automatic logic [ADDR_W-1:0] exp_erase(input fesc_op_t k, input logic [19:0] x);
        return (k == FESC_OP_CHIP) ? 20'h00555 : x;
    endfunction
    // level request held for one clock, then a bounded wait for done
    task automatic run_op(input fesc_op_t k, input logic [ADDR_W-1:0] x, input logic lg);
        int n;
        @(negedge clk);
        op = k;
        req_addr = x;
        sector_large = lg;
        req = 1'b1;
        @(negedge clk);
        req = 1'b0;
        n = 0;
        while (done_q !== 1'b1 && n < 20000)
        begin
            @(negedge clk);
            n++;
        end
        check(n < 20000, 1);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge clk)
    begin
        cyc++;
        if (cyc > 40000)
        begin
            err_count++;
            finish_test();
        end
    end
    initial
    begin
        void'($urandom(76));
        repeat (5) @(negedge clk);
        rst = 1'b0;
        check({ce_n, oe_n, we_n, dq_oe, busy_q}, 5'b11100);
        run_op(FESC_OP_ID_ENTRY, '0, 1'b0);
        check(id_mode_q, 1);
        check(maker_code_q, exp_code(1'b0));
        check(device_code_q, exp_code(1'b1));
        run_op(FESC_OP_ID_EXIT, '0, 1'b0);
        check(id_on, 0);
        check(id_mode_q, 0);
        // chip then random sectors, back to back, upper address bits random
        for (int i = 0; i < 6; i++)
        begin
            o = (i == 0) ? FESC_OP_CHIP : FESC_OP_SECTOR;
            ad = ADDR_W'($urandom);
            run_op(o, ad, 1'($urandom_range(0, 1)));
            check(erase_cmd, (o == FESC_OP_CHIP) ? CHIP_ERASE : SECTOR_ERASE);
            check(erase_addr, exp_erase(o, ad));
            check(timeout_q, 0);
        end
        // toggle never settles: only the timeout ends the poll
        stuck = 1'b1;
        run_op(FESC_OP_SECTOR, ADDR_W'($urandom), 1'b0);
        check(timeout_q, 1);
        stuck = 1'b0;
        run_op(FESC_OP_CHIP, 20'h00ABC, 1'b0);
        check(timeout_q, 0);
        run_op(FESC_OP_ID_ENTRY, '0, 1'b0);
        pwr_off = 1'b1;
        @(negedge clk);
        pwr_off = 1'b0;
        check(id_on, 0);
        finish_test();
    end
endmodule
bind fesc_ctrl fesc_monitor i_fesc_monitor (.clk(clk), .rst(rst), .req(req), .op(op),
    .req_addr(req_addr), .busy_q(busy_q), .done_q(done_q), .timeout_q(timeout_q),
    .oe_n(oe_n), .we_n(we_n), .a(a), .dq_out(dq_out), .dq_oe(dq_oe));
